/* hw/jtp_tap.sv */
// Purpose: boundary-scan test access port with an ahb-lite status window
// Assumes: tck, tms, tdi and the io ring are asynchronous to i_ref_clk, tck far slower
// Notes:   tck is oversampled; edges are seen two to three reference cycles late
//
// Design decisions made here: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "jtp_regs.svh"

// Functional notes
// - extest outputs change only entering update-dr
// - shift ir serially, apply at update-ir
// - five tms-high edges reach reset, memory untouched
// - power-up resets tap, tdo high-z
// - one scan register selected by instruction
// - sample tdi rising, drive tdo falling
// - 8-bit ir loads idcode at reset
// - capture-ir loads low bits 01
// - one-bit bypass, cleared on capture
// - 113-bit bsr, msb from tdi
// - capture-dr loads io ring, then shifts
// - idcode captured then shifted out
// - id fields revision, device, vendor, one
// - decode extest, sample/preload, idcode codes
// - decode clamp, highz, bypass codes
// - clamp drives outputs from bsr, bypass scanned
// - highz floats outputs, bypass scanned
// - extest drives vector, enabled at update-ir
// - sample/preload snapshots inputs at capture-dr
// - unused bsr positions read zero
// - tdo driven only in shift states
module jtp_tap #(
   parameter logic [3:0]              ID_REV      = 4'h1,     // arbitrary value
   parameter logic [15:0]             ID_DEVICE   = 16'h1234, // arbitrary value
   parameter logic [10:0]             ID_VENDOR   = 11'h155,  // arbitrary value
   parameter int unsigned             BSR_LEN     = `JTP_BSR_LEN,
   parameter logic [BSR_LEN-1:0]      UNUSED_MASK = '0
) (
   // clock and reset
   input  wire logic                  i_ref_clk,
   input  wire logic                  i_arst_n,
   // scan pins
   input  wire logic                  i_tck,
   input  wire logic                  i_tms,
   input  wire logic                  i_tdi,
   output logic                       o_tdo,
   output logic                       o_tdo_oe,
   // io ring
   input  wire logic [BSR_LEN-1:0]    i_ring_in,
   output logic [BSR_LEN-1:0]         o_ring_out,
   output logic                       o_ring_test,
   output logic                       o_ring_hiz,
   // ahb-lite slave
   input  wire jtp_pkg::jtp_ahb_req_t i_ahb,
   output logic [31:0]                o_hrdata,
   output logic                       o_hreadyout,
   output logic                       o_hresp
);
   import jtp_pkg::*;

   // ==========================================================
   // reset release and pin synchronisers
   logic [1:0]         rst_q;
   logic               rst_n;
   logic [2:0]         pin_s1;
   logic [2:0]         pin_s2;
   logic [BSR_LEN-1:0] ring_s1;
   logic [BSR_LEN-1:0] ring_s2;
   logic               tck_q;

   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_q <= 2'h0;
      end else begin
         rst_q <= {rst_q[0], 1'b1};
      end
   end
   assign rst_n = rst_q[1];

   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1  <= 3'h0;
         pin_s2  <= 3'h0;
         ring_s1 <= '0;
         ring_s2 <= '0;
         tck_q   <= 1'b0;
      end else begin
         pin_s1  <= {i_tck, i_tms, i_tdi};
         pin_s2  <= pin_s1;
         ring_s1 <= i_ring_in;
         ring_s2 <= ring_s1;
         tck_q   <= pin_s2[2];
      end
   end

   wire tck_s    = pin_s2[2];
   wire tms_s    = pin_s2[1];
   wire tdi_s    = pin_s2[0];
   wire tck_rise = tck_s & ~tck_q;
   wire tck_fall = ~tck_s & tck_q;

   // ==========================================================
   // controller
   function automatic jtp_state_t tap_next(input jtp_state_t s, input logic tms);
      case (s)
         ST_TLR:    tap_next = tms ? ST_TLR    : ST_RTI;
         ST_RTI:    tap_next = tms ? ST_SEL_DR : ST_RTI;
         ST_SEL_DR: tap_next = tms ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: tap_next = tms ? ST_EX1_DR : ST_SH_DR;
         ST_SH_DR:  tap_next = tms ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR: tap_next = tms ? ST_UPD_DR : ST_PAU_DR;
         ST_PAU_DR: tap_next = tms ? ST_EX2_DR : ST_PAU_DR;
         ST_EX2_DR: tap_next = tms ? ST_UPD_DR : ST_SH_DR;
         ST_UPD_DR: tap_next = tms ? ST_SEL_DR : ST_RTI;
         ST_SEL_IR: tap_next = tms ? ST_TLR    : ST_CAP_IR;
         ST_CAP_IR: tap_next = tms ? ST_EX1_IR : ST_SH_IR;
         ST_SH_IR:  tap_next = tms ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR: tap_next = tms ? ST_UPD_IR : ST_PAU_IR;
         ST_PAU_IR: tap_next = tms ? ST_EX2_IR : ST_PAU_IR;
         ST_EX2_IR: tap_next = tms ? ST_UPD_IR : ST_SH_IR;
         ST_UPD_IR: tap_next = tms ? ST_SEL_DR : ST_RTI;
         default:   tap_next = ST_TLR;
      endcase
   endfunction

   // reserved codes fall back to bypass so a stray code cannot disturb the ring
   function automatic jtp_path_t path_of(input logic [`JTP_IR_LEN-1:0] ins);
      case (ins)
         `JTP_INS_EXTEST: path_of = PATH_BSR;
         `JTP_INS_SAMPLE: path_of = PATH_BSR;
         `JTP_INS_IDCODE: path_of = PATH_ID;
         default:         path_of = PATH_BYP;
      endcase
   endfunction

   jtp_state_t              st;
   jtp_state_t              next_st;
   logic [`JTP_IR_LEN-1:0]  ir;
   logic [`JTP_IR_LEN-1:0]  ir_sh;
   logic                    byp;
   logic [`JTP_ID_LEN-1:0]  id_sh;
   logic [BSR_LEN-1:0]      bsr_sh;
   logic                    trst_req;
   logic [15:0]             upd_cnt;
   logic [2:0]              tms_cnt;

   wire [`JTP_ID_LEN-1:0] id_value = {ID_REV, ID_DEVICE, ID_VENDOR, 1'b1};
   wire jtp_path_t        path     = path_of(ir);
   wire                   is_extest = (ir == `JTP_INS_EXTEST);
   wire                   is_sample = (ir == `JTP_INS_SAMPLE);
   wire                   ins_drive = is_extest | (ir == `JTP_INS_CLAMP);
   wire                   ins_hiz   = (ir == `JTP_INS_HIGHZ);
   wire                   to_upd_dr = tck_rise & (next_st == ST_UPD_DR);
   wire                   to_upd_ir = tck_rise & (next_st == ST_UPD_IR);
   wire                   shift_st  = (st == ST_SH_DR) | (st == ST_SH_IR);

   assign next_st = tap_next(st, tms_s);

   // a software reset request is taken on the next reference cycle, no tck needed
   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= ST_TLR;
      end else if (trst_req) begin
         st <= ST_TLR;
      end else if (tck_rise) begin
         st <= next_st;
      end
   end

   // counts tms-high edges; only for checking the five-edge reset path
   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tms_cnt <= 3'h0;
      end else if (tck_rise) begin
         tms_cnt <= !tms_s ? 3'h0 : (tms_cnt == 3'h5) ? tms_cnt : tms_cnt + 3'h1;
      end
   end

   // ==========================================================
   // instruction register
   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ir    <= `JTP_INS_IDCODE;
         ir_sh <= `JTP_IR_CAPTURE;
      end else if (trst_req || (tck_rise && next_st == ST_TLR)) begin
         ir    <= `JTP_INS_IDCODE;
      end else if (tck_rise) begin
         if (st == ST_CAP_IR) begin
            ir_sh <= `JTP_IR_CAPTURE;
         end else if (st == ST_SH_IR) begin
            ir_sh <= {tdi_s, ir_sh[`JTP_IR_LEN-1:1]};
         end
         if (to_upd_ir) begin
            ir <= ir_sh;
         end
      end
   end

   // ==========================================================
   // data registers
   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         byp    <= 1'b0;
         id_sh  <= '0;
         bsr_sh <= '0;
      end else if (tck_rise && st == ST_CAP_DR) begin
         case (path)
            PATH_BYP: byp    <= 1'b0;
            PATH_ID:  id_sh  <= id_value;
            PATH_BSR: bsr_sh <= ring_s2 & ~UNUSED_MASK;
            default:  byp    <= 1'b0;
         endcase
      end else if (tck_rise && st == ST_SH_DR) begin
         case (path)
            PATH_BYP: byp    <= tdi_s;
            PATH_ID:  id_sh  <= {tdi_s, id_sh[`JTP_ID_LEN-1:1]};
            PATH_BSR: bsr_sh <= {tdi_s, bsr_sh[BSR_LEN-1:1]};
            default:  byp    <= tdi_s;
         endcase
      end
   end

   // update latch moves only on entry to update-dr
   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_ring_out <= '0;
         upd_cnt    <= 16'h0;
      end else if (to_upd_dr) begin
         upd_cnt <= upd_cnt + 16'h1;
         if (is_extest || is_sample) begin
            o_ring_out <= bsr_sh;
         end
      end
   end

   // mode outputs follow the active instruction, so they switch at update-ir
   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_ring_test <= 1'b0;
         o_ring_hiz  <= 1'b0;
      end else begin
         o_ring_test <= ins_drive;
         o_ring_hiz  <= ins_hiz;
      end
   end

   // ==========================================================
   // tdo, launched on the falling tck edge
   wire tdo_src = (st == ST_SH_IR)   ? ir_sh[0] :
                  (path == PATH_BSR) ? bsr_sh[0] :
                  (path == PATH_ID)  ? id_sh[0] : byp;

   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_tdo    <= 1'b0;
         o_tdo_oe <= 1'b0;
      end else if (tck_fall) begin
         o_tdo    <= tdo_src;
         o_tdo_oe <= shift_st;
      end
   end

   // ==========================================================
   // ahb-lite slave, zero wait states, always okay
   logic       dp_wr;
   logic [7:0] dp_addr;

   wire ap_valid = i_ahb.hsel & i_ahb.htrans[1] & i_ahb.hready;
   wire [7:0] ap_addr = i_ahb.haddr[7:0];
   wire [31:0] status_word = {13'h0, o_ring_hiz, o_ring_test, o_tdo_oe, ir, 4'h0, st};
   wire [31:0] rd_data = (ap_addr == `JTP_OFS_STATUS)  ? status_word :
                         (ap_addr == `JTP_OFS_CTRL)    ? {31'h0, trst_req} :
                         (ap_addr == `JTP_OFS_IDCODE)  ? id_value :
                         (ap_addr == `JTP_OFS_UPD_CNT) ? {16'h0, upd_cnt} : 32'h0;
   wire sw_wr_ctrl = dp_wr & (dp_addr == `JTP_OFS_CTRL);

   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         dp_wr       <= 1'b0;
         dp_addr     <= 8'h0;
         o_hrdata    <= 32'h0;
         o_hreadyout <= 1'b0;
         o_hresp     <= 1'b0;
      end else begin
         o_hreadyout <= 1'b1;
         o_hresp     <= 1'b0;
         dp_wr       <= ap_valid & i_ahb.hwrite;
         if (ap_valid) begin
            dp_addr  <= ap_addr;
            o_hrdata <= i_ahb.hwrite ? 32'h0 : rd_data;
         end
      end
   end

   // tap reset never touches o_ring_out, only clears o_ring_test and o_ring_hiz, so the memory keeps running
   always_ff @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         trst_req <= `JTP_CTRL_RESET;
      end else if (sw_wr_ctrl) begin
         trst_req <= i_ahb.hwdata[`JTP_CTRL_TRST_BIT];
      end else if (st == ST_TLR) begin
         trst_req <= 1'b0;
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!rst_n);

   sequence s_cap_dr(jtp_path_t p);
      tck_rise && st == ST_CAP_DR && path == p;
   endsequence

   sequence s_sh_bsr;
      tck_rise && st == ST_SH_DR && path == PATH_BSR;
   endsequence

   a_ring_hold: assert property (!to_upd_dr |=> $stable(o_ring_out))
      else $error("ring outputs changed outside update-dr entry");
   a_ir_apply: assert property ($changed(ir) && st != ST_TLR |-> st == ST_UPD_IR)
      else $error("instruction changed outside update-ir");
   a_tms_reset: assert property (tms_cnt == 3'h5 |-> st == ST_TLR)
      else $error("five tms-high edges did not reach reset");
   a_ir_idcode: assert property (st == ST_TLR |-> ir == `JTP_INS_IDCODE)
      else $error("reset state without idcode instruction");
   a_capture_ir: assert property (tck_rise && st == ST_CAP_IR |=> ir_sh[1:0] == 2'b01)
      else $error("capture-ir did not load 01");
   a_bypass_clear: assert property (s_cap_dr(PATH_BYP) |=> byp == 1'b0)
      else $error("bypass not cleared at capture");
   a_id_capture: assert property (s_cap_dr(PATH_ID) |=> id_sh == id_value)
      else $error("idcode not captured");
   a_unused_zero: assert property (s_cap_dr(PATH_BSR) |=> (bsr_sh & UNUSED_MASK) == '0)
      else $error("unused boundary position captured non-zero");
   a_bsr_shift: assert property (s_sh_bsr |=> bsr_sh[BSR_LEN-1] == $past(tdi_s))
      else $error("boundary msb not fed from tdi");
   a_tdo_float: assert property (tck_fall && !shift_st |=> !o_tdo_oe)
      else $error("tdo driven outside shift states");
   a_hiz_mode: assert property (ir == `JTP_INS_HIGHZ |=> o_ring_hiz && !o_ring_test)
      else $error("highz instruction did not float outputs");

endmodule

/* include/jtp_regs.svh */
// Purpose: register offsets, field positions, reset values and codes of the scan port
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes:   definitions only
`ifndef JTP_REGS_SVH
`define JTP_REGS_SVH

// ==========================================================
// register byte offsets
`define JTP_OFS_STATUS      8'h00
`define JTP_OFS_CTRL        8'h04
`define JTP_OFS_IDCODE      8'h08
`define JTP_OFS_UPD_CNT     8'h0C

// ==========================================================
// field positions
`define JTP_ST_STATE_LSB    0
`define JTP_ST_INSTR_LSB    8
`define JTP_ST_TDO_OE_BIT   16
`define JTP_ST_TEST_BIT     17
`define JTP_ST_HIZ_BIT      18
`define JTP_CTRL_TRST_BIT   0

// ==========================================================
// scan register sizes and reset values
`define JTP_IR_LEN          8
`define JTP_ID_LEN          32
`define JTP_BSR_LEN         113
`define JTP_IR_CAPTURE      8'h01
`define JTP_CTRL_RESET      1'b0

// ==========================================================
// instruction codes
`define JTP_INS_EXTEST      8'h00
`define JTP_INS_SAMPLE      8'h05
`define JTP_INS_IDCODE      8'h21
`define JTP_INS_CLAMP       8'h07
`define JTP_INS_HIGHZ       8'h03
`define JTP_INS_BYPASS      8'hFF

`endif

/* include/jtp_pkg.sv */
// Purpose: types shared by the scan port and its bench
// Assumes: nothing
// Notes:   states carry no explicit codes
package jtp_pkg;

   // ==========================================================
   // controller states
   typedef enum logic [3:0] {
      ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR, ST_UPD_DR,
      ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
   } jtp_state_t;

   // ==========================================================
   // data path selected by the instruction
   typedef enum logic [1:0] {
      PATH_BYP, PATH_ID, PATH_BSR
   } jtp_path_t;

   // ==========================================================
   // ahb-lite request from the master
   typedef struct packed {
      logic        hsel;
      logic [31:0] haddr;
      logic [1:0]  htrans;
      logic        hwrite;
      logic [2:0]  hsize;
      logic [31:0] hwdata;
      logic        hready;
   } jtp_ahb_req_t;

endpackage

/* verification/jtp_ctl_model.sv */
// Purpose: behavioural boundary-scan test controller at the far side of the scan port
// Assumes: tck idles low between frames, period 800 ns
// Notes:   tms and tdi settle half a period before each rise to cover the sync lag
`timescale 1ns/1ps
module jtp_ctl_model (
   // reference clock, used only for phase alignment
   input  wire logic i_ref_clk,
   // scan pins
   input  wire logic i_tdo,
   input  wire logic i_tdo_oe,
   output logic      o_tck,
   output logic      o_tms,
   output logic      o_tdi
);
   // ==========================================================
   // one tck cycle, tdo taken just before the rise
   initial begin
      o_tck = 1'b0;
      o_tms = 1'b1;
      o_tdi = 1'b1;
   end
   task automatic step(input logic tms, input logic tdi, output logic tdo, output logic oe);
      o_tms = tms;
      o_tdi = tdi;
      #400;
      // tdo has no pull, so a floating pin reads as the inverse of the last bit
      tdo = i_tdo_oe ? i_tdo : ~i_tdo;
      oe = i_tdo_oe;
      o_tck = 1'b1;
      #400;
      o_tck = 1'b0;
   endtask
   // ==========================================================
   // tms walk, lsb first, tdi at its pull-up level
   task automatic move(input int n, input logic [7:0] bits);
      logic d, e;
      @(posedge i_ref_clk);
      #7;
      for (int k = 0; k < n; k++) begin
         step(bits[k], 1'b1, d, e);
      end
   endtask
   // ==========================================================
   // full scan from run-test/idle back to run-test/idle through update
   task automatic scan(input logic ir, input int len, input logic [112:0] din,
                       output logic [112:0] dout, output logic oe_ok);
      logic d, e;
      dout = '0;
      oe_ok = 1'b1;
      move(ir ? 4 : 3, ir ? 8'h03 : 8'h01);
      for (int k = 0; k < len; k++) begin
         step(k == len - 1, din[k], d, e);
         dout[k] = d;
         oe_ok = oe_ok & (e === 1'b1);
      end
      step(1'b1, 1'b1, d, e);
      oe_ok = oe_ok & (e === 1'b0);
      step(1'b0, 1'b1, d, e);
   endtask
endmodule

/* verification/tb.sv */
// Purpose: self-checking bench of the scan port
// Assumes: one controller model on the scan pins, ahb-lite master in the bench
// Notes:   ring inputs change only while no capture is near
`timescale 1ns/1ps
`include "jtp_regs.svh"
module tb;
   import jtp_pkg::*;
   // ==========================================================
   // parameters and signals
   localparam logic [3:0]   REV    = 4'h9;    // arbitrary value
   localparam logic [15:0]  DEVID  = 16'h5AC3; // arbitrary value
   localparam logic [10:0]  VEND   = 11'h2B6;  // arbitrary value
   localparam logic [112:0] UNUSED = {1'b1, 104'h0, 8'h81};
   localparam logic [112:0] PAT    = {1'b1, {7{16'hA5C3}}};
   logic         clk, arst_n, hready, tck, tms, tdi, tdo, tdo_oe, ring_test, ring_hiz, hresp;
   logic [112:0] ring_in, ring_out;
   logic [31:0]  hrdata;
   jtp_ahb_req_t req, ahb;
   int           error_cnt, comparisons, cyc, upd_seen;
   jtp_tap #(.ID_REV(REV), .ID_DEVICE(DEVID), .ID_VENDOR(VEND), .BSR_LEN(113), .UNUSED_MASK(UNUSED)) DUT (
      .i_ref_clk(clk), .i_arst_n(arst_n), .i_tck(tck), .i_tms(tms), .i_tdi(tdi), .o_tdo(tdo),
      .o_tdo_oe(tdo_oe), .i_ring_in(ring_in), .o_ring_out(ring_out), .o_ring_test(ring_test),
      .o_ring_hiz(ring_hiz), .i_ahb(ahb), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp));
   jtp_ctl_model ctl (.i_ref_clk(clk), .i_tdo(tdo), .i_tdo_oe(tdo_oe), .o_tck(tck), .o_tms(tms), .o_tdi(tdi));
   always_comb begin
      ahb = req;
      ahb.hready = hready;
   end
   always @(ring_out) upd_seen++;
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // a hung handshake must still reach the verdict
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         finish_test();
      end
   end
   // ==========================================================
   // helpers
   task automatic chk(input logic [112:0] got, input logic [112:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic bus_xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clk);
      req <= '{hsel: 1'b1, haddr: a, htrans: 2'b10, hwrite: wr, hsize: 3'b010, default: '0};
      do @(posedge clk); while (hready !== 1'b1);
      req <= '{hwdata: wd, default: '0};
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic set_ir(input logic [7:0] code);
      logic [112:0] q;
      logic [31:0]  d;
      logic         ok;
      ctl.scan(1'b1, 8, {105'h0, code}, q, ok);
      chk(q[7:0], `JTP_IR_CAPTURE);
      chk(ok, 1'b1);
      bus_xfer(1'b0, `JTP_OFS_STATUS, 32'h0, d);
      chk(d[15:8], code);
      chk(d[3:0], ST_RTI);
   endtask
   // ==========================================================
   // scenarios
   task automatic t_reset();
      logic [31:0] d;
      chk(tdo_oe, 1'b0);
      bus_xfer(1'b0, `JTP_OFS_STATUS, 32'h0, d);
      chk(d[15:8], `JTP_INS_IDCODE);
      chk(d[3:0], ST_TLR);
      bus_xfer(1'b0, `JTP_OFS_IDCODE, 32'h0, d);
      chk(d, {REV, DEVID, VEND, 1'b1});
      bus_xfer(1'b1, 32'h40, 32'hFFFF_FFFF, d);
      bus_xfer(1'b0, 32'h40, 32'h0, d);
      chk(d, 32'h0);
      chk(hresp, 1'b0);
      // leave test-logic-reset so every scan starts from run-test/idle
      ctl.move(1, 8'h00);
      $display("t_reset done");
   endtask
   task automatic t_idcode();
      logic [112:0] q;
      logic         ok;
      ctl.scan(1'b0, 32, 113'h0, q, ok);
      chk(q[31:0], {REV, DEVID, VEND, 1'b1});
      chk(ok, 1'b1);
      $display("t_idcode done");
   endtask
   task automatic t_bypass();
      logic [7:0]   codes [3] = '{`JTP_INS_BYPASS, `JTP_INS_CLAMP, `JTP_INS_HIGHZ};
      logic [112:0] q, held;
      logic         ok;
      held = ring_out;
      foreach (codes[i]) begin
         set_ir(codes[i]);
         chk(ring_test, codes[i] == `JTP_INS_CLAMP);
         chk(ring_hiz, codes[i] == `JTP_INS_HIGHZ);
         ctl.scan(1'b0, 4, 113'hB, q, ok);
         chk(q[3:0], 4'h6);
         chk(ok, 1'b1);
         chk(ring_out, held);
      end
      $display("t_bypass done");
   endtask
   task automatic t_sample();
      logic [112:0] q;
      logic         ok;
      @(posedge clk);
      ring_in <= PAT;
      set_ir(`JTP_INS_SAMPLE);
      ctl.scan(1'b0, 113, ~PAT, q, ok);
      chk(q, PAT & ~UNUSED);
      chk(ring_out, ~PAT);
      $display("t_sample done");
   endtask
   task automatic t_extest();
      logic [112:0] q;
      logic [31:0]  c0, d;
      logic         ok;
      int           seen;
      bus_xfer(1'b0, `JTP_OFS_UPD_CNT, 32'h0, c0);
      set_ir(`JTP_INS_EXTEST);
      chk(ring_test, 1'b1);
      chk(ring_out, ~PAT);
      @(posedge clk);
      ring_in <= ~PAT;
      seen = upd_seen;
      ctl.scan(1'b0, 113, PAT, q, ok);
      chk(q, ~PAT & ~UNUSED);
      chk(ring_out, PAT);
      chk(upd_seen - seen, 1);
      bus_xfer(1'b0, `JTP_OFS_UPD_CNT, 32'h0, d);
      chk(d[15:0], c0[15:0] + 16'h1);
      $display("t_extest done");
   endtask
   task automatic t_tap_reset();
      logic [112:0] held;
      logic [31:0]  d;
      int           n;
      ctl.move(5, 8'h09);
      bus_xfer(1'b0, `JTP_OFS_STATUS, 32'h0, d);
      chk(d[3:0], ST_PAU_DR);
      chk(d[16], 1'b0);
      ctl.move(3, 8'h03);
      held = ring_out;
      ctl.move(5, 8'h1F);
      bus_xfer(1'b0, `JTP_OFS_STATUS, 32'h0, d);
      chk(d[3:0], ST_TLR);
      chk(d[15:8], `JTP_INS_IDCODE);
      chk(ring_out, held);
      ctl.move(1, 8'h00);
      set_ir(`JTP_INS_BYPASS);
      bus_xfer(1'b1, `JTP_OFS_CTRL, 32'h1, d);
      n = 0;
      do begin
         bus_xfer(1'b0, `JTP_OFS_CTRL, 32'h0, d);
         n++;
      end while (d[0] !== 1'b0 && n < 20);
      chk(d[0], 1'b0);
      bus_xfer(1'b0, `JTP_OFS_STATUS, 32'h0, d);
      chk(d[15:8], `JTP_INS_IDCODE);
      chk(d[3:0], ST_TLR);
      ctl.move(1, 8'h00);
      t_idcode();
      $display("t_tap_reset done");
   endtask
   // reset in mid-shift: tdo must float at once, tap back in reset
   task automatic t_power_reset();
      logic [31:0] d;
      ctl.move(4, 8'h01);
      repeat (5) @(posedge clk);
      chk(tdo_oe, 1'b1);
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      chk(tdo_oe, 1'b0);
      arst_n <= 1'b1;
      repeat (10) @(posedge clk);
      bus_xfer(1'b0, `JTP_OFS_STATUS, 32'h0, d);
      chk(d[3:0], ST_TLR);
      chk(d[15:8], `JTP_INS_IDCODE);
      chk(d[16], 1'b0);
      ctl.move(1, 8'h00);
      t_idcode();
      $display("t_power_reset done");
   endtask
   // ==========================================================
   // verdict and main sequence
   task automatic finish_test();
      $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      arst_n = 1'b0;
      req = '0;
      ring_in = '0;
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      repeat (10) @(posedge clk);
      t_reset();
      t_idcode();
      t_bypass();
      t_sample();
      t_extest();
      t_tap_reset();
      t_power_reset();
      finish_test();
   end
endmodule
